// *** verilog/lccr_link_cap_regs.sv ***
// link capability header: link_capability_identifier, next pointer and link command register
`timescale 1ns/1ps
`include "lccr_consts.svh"

// How it works
// - link_capability_identifier byte is read-only and always returns 08h.
// - single and dual modes: next pointer reads 00h, no more capabilities.
// - generic single and dual modes: next pointer reads 78h, interrupt block.
// - command bits 15:13 read-only, always primary block type 000b.
// - generic modes, drop bit set, link uninitialised: packets treated as end-of-chain.
// - drop bit clear, neither flag set: stall forwarding until one flag sets.
// - direction 0 sends requests toward master host link, 1 the other way.
// - direction bit writable, cleared by warm reset.
// - single modes: any command write loads master host with the carrying link.
// - dual modes: master host reads 0 via nearer link, 1 via farther.
// - unit count field read-only, always reports one unit id.
// - base unit id writable, sets first unit id, cleared by warm reset.
// - generic modes: secondary address parity error with serr enable floods sync.
module lccr_link_cap_regs #(
    parameter int NUM_LINKS = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic warm_rst_n,
    input wire logic [1:0] mode_strap,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic cfg_link,
    output logic [31:0] cfg_rdata,
    output logic cfg_rvalid,
    output logic cfg_rhit,
    input wire logic [NUM_LINKS-1:0] link_init_done,
    input wire logic [NUM_LINKS-1:0] link_eoc,
    input wire logic [NUM_LINKS-1:0] pkt_valid,
    output logic [NUM_LINKS-1:0] fwd_go,
    output logic [NUM_LINKS-1:0] fwd_drop,
    output logic [NUM_LINKS-1:0] fwd_stall,
    input wire logic sec_addr_perr,
    input wire logic serr_en,
    output logic req_link_sel,
    output logic [4:0] base_unit_id,
    output logic sync_flood
);

    // routing and the master host bit assume a nearer and a farther link only
    if (NUM_LINKS != 2) begin : g_bad_links
        $error("lccr_link_cap_regs serves exactly two links");
    end

    // merge one written byte lane into the bits that software may change
    function automatic logic [7:0] lccr_merge(
        input logic [7:0] old_val,
        input logic [7:0] new_val,
        input logic [7:0] wr_mask,
        input logic lane_en
    );
        logic [7:0] res;
        res = old_val;
        if (lane_en) begin
            res = (old_val & ~wr_mask) | (new_val & wr_mask);
        end
        return res;
    endfunction : lccr_merge

    // mode decodes shared by the read view, the gate controls and routing
    function automatic logic lccr_mode_generic(
        input lccr_pkg::lccr_mode_t mode
    );
        return (mode == lccr_pkg::LCCR_MODE_GEN_SINGLE) ||
               (mode == lccr_pkg::LCCR_MODE_GEN_DUAL);
    endfunction : lccr_mode_generic

    function automatic logic lccr_mode_dual(
        input lccr_pkg::lccr_mode_t mode
    );
        return (mode == lccr_pkg::LCCR_MODE_DUAL) ||
               (mode == lccr_pkg::LCCR_MODE_GEN_DUAL);
    endfunction : lccr_mode_dual

    // link for device requests: direction 0 points at the master host
    function automatic logic lccr_route(
        input logic dir,
        input logic mhost
    );
        return dir ? ~mhost : mhost;
    endfunction : lccr_route

    // assemble the header dword as the host sees it
    function automatic logic [31:0] lccr_hdr_word(
        input logic [15:0] cmd,
        input logic [7:0] ptr
    );
        return {cmd, ptr, `LCCR_CAP_ID_VAL};
    endfunction : lccr_hdr_word

    lccr_pkg::lccr_mode_t mode_reg;
    logic mode_held_reg;
    logic drop_reg;
    logic dir_reg;
    logic mhost_reg;
    logic [4:0] unit_id_reg;
    logic flood_reg;
    logic [31:0] rdata_reg;
    logic rvalid_reg;
    logic rhit_reg;
    logic route_reg;
    logic [1:0] strap_s1_reg;
    logic [1:0] strap_s2_reg;
    logic [1:0] settle_reg;

    logic is_generic;
    logic is_dual;
    logic hdr_hit;
    logic cmd_wr;
    logic [7:0] cmd_lo_next;
    logic [7:0] cmd_hi_next;
    logic [15:0] cmd_view;
    logic [7:0] next_ptr;

    lccr_ctl_if #(.NUM_LINKS(NUM_LINKS)) ctl_bus ();

    assign is_generic = lccr_mode_generic(mode_reg);
    assign is_dual = lccr_mode_dual(mode_reg);
    assign hdr_hit = (cfg_addr[7:2] == `LCCR_CAP_DW_IDX);
    assign cmd_wr = cfg_wr && hdr_hit && (cfg_be[2] || cfg_be[3]);

    // the strap pin is asynchronous to clk: two flops before anything reads it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_s1_reg <= 2'h0;
            strap_s2_reg <= 2'h0;
        end else begin
            strap_s1_reg <= mode_strap;
            strap_s2_reg <= strap_s1_reg;
        end
    end

    // capture waits for real strap values, not the synchroniser's reset zeros
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            settle_reg <= 2'h0;
        end else begin
            settle_reg <= {settle_reg[0], 1'b1};
        end
    end

    // the mode strap is caught once after reset release, then held
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= lccr_pkg::LCCR_MODE_SINGLE;
            mode_held_reg <= 1'b0;
        end else if (!mode_held_reg && settle_reg[1]) begin
            mode_reg <= lccr_pkg::lccr_mode_t'(strap_s2_reg);
            mode_held_reg <= 1'b1;
        end
    end

    // writable bits only; fixed fields have no storage at all
    always_comb begin
        cmd_lo_next = lccr_merge({3'h0, unit_id_reg}, cfg_wdata[23:16], 8'h1f,
                                 cfg_be[2]);
        cmd_hi_next = lccr_merge({3'h0, drop_reg, dir_reg, 3'h0}, cfg_wdata[31:24],
                                 {3'h0, is_generic, 1'b1, 3'h0},
                                 cfg_be[3]);
    end

    // drop control: only generic modes may change it; warm reset clears it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drop_reg <= `LCCR_DROP_RST;
        end else if (!warm_rst_n) begin
            drop_reg <= `LCCR_DROP_RST;
        end else if (cmd_wr) begin
            drop_reg <= cmd_hi_next[`LCCR_DROP_BIT - 8];
        end
    end

    // default direction does not survive a warm reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_reg <= `LCCR_DIR_RST;
        end else if (!warm_rst_n) begin
            dir_reg <= `LCCR_DIR_RST;
        end else if (cmd_wr) begin
            dir_reg <= cmd_hi_next[`LCCR_DIR_BIT - 8];
        end
    end

    // base unit id: host writable, cleared by warm reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            unit_id_reg <= `LCCR_UNIT_ID_RST;
        end else if (!warm_rst_n) begin
            unit_id_reg <= `LCCR_UNIT_ID_RST;
        end else if (cmd_wr) begin
            unit_id_reg <= cmd_lo_next[4:0];
        end
    end

    // in single modes, master host follows the link that carried any write to the command register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mhost_reg <= `LCCR_MHOST_RST;
        end else if (cmd_wr && warm_rst_n && !is_dual) begin
            mhost_reg <= cfg_link;
        end
    end

    // dual modes keep one copy per link; the copy read is the one behind the carrying link
    always_comb begin
        cmd_view = '0;
        cmd_view[`LCCR_CAP_TYPE_HI:`LCCR_CAP_TYPE_LO] = `LCCR_CAP_TYPE_VAL;
        cmd_view[`LCCR_DROP_BIT] = is_generic & drop_reg;
        cmd_view[`LCCR_DIR_BIT] = dir_reg;
        cmd_view[`LCCR_MHOST_BIT] = is_dual ? cfg_link : mhost_reg;
        cmd_view[`LCCR_UNIT_CNT_HI:`LCCR_UNIT_CNT_LO] = `LCCR_UNIT_CNT_VAL;
        cmd_view[`LCCR_UNIT_ID_HI:`LCCR_UNIT_ID_LO] = unit_id_reg;
    end

    // the pointer tells software whether the interrupt block follows
    always_comb begin
        next_ptr = is_generic ? `LCCR_NEXT_PTR_INTR : `LCCR_NEXT_PTR_NONE;
    end

    // read answer one cycle after the request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= cfg_rd;
        end
    end

    // hit marks reads of the header dword; other dwords read zero with no hit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rhit_reg <= 1'b0;
        end else begin
            rhit_reg <= cfg_rd && hdr_hit;
        end
    end

    // data holds until the next read so a slow host can still pick it up
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= '0;
        end else if (cfg_rd && hdr_hit) begin
            rdata_reg <= lccr_hdr_word(cmd_view, next_ptr);
        end else if (cfg_rd) begin
            rdata_reg <= '0;
        end
    end

    // device requests: direction 0 goes toward master host; dual routes via copy of link 0
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            route_reg <= 1'b0;
        end else if (is_dual) begin
            route_reg <= lccr_route(dir_reg, 1'b0);
        end else begin
            route_reg <= lccr_route(dir_reg, mhost_reg);
        end
    end

    // sync flood is terminal: only a reset ends it, since the links are no longer trusted
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flood_reg <= 1'b0;
        end else if (!warm_rst_n) begin
            flood_reg <= 1'b0;
        end else if (is_generic && sec_addr_perr && serr_en) begin
            flood_reg <= 1'b1;
        end
    end

    assign ctl_bus.generic_mode = is_generic;
    assign ctl_bus.drop_uninit = drop_reg;
    assign ctl_bus.init_done = link_init_done;
    assign ctl_bus.end_of_chain = link_eoc;
    assign ctl_bus.pkt_valid = pkt_valid;

    lccr_fwd_gate #(
        .NUM_LINKS(NUM_LINKS)
    ) u_gate (
        .clk(clk),
        .rst_n(rst_n),
        .warm_rst_n(warm_rst_n),
        .ctl(ctl_bus.gate)
    );

    // every output is a flop here or in the gate, so none glitches
    assign fwd_go = ctl_bus.fwd_go;
    assign fwd_drop = ctl_bus.fwd_drop;
    assign fwd_stall = ctl_bus.fwd_stall;
    assign cfg_rdata = rdata_reg;
    assign cfg_rvalid = rvalid_reg;
    assign cfg_rhit = rhit_reg;
    assign req_link_sel = route_reg;
    assign base_unit_id = unit_id_reg;
    assign sync_flood = flood_reg;

endmodule : lccr_link_cap_regs

// *** verilog/lccr_consts.svh ***
// offsets, field positions, reset values and fixed codes of the link capability header
`ifndef LCCR_CONSTS_SVH
`define LCCR_CONSTS_SVH

// dword index of the header: byte 0x40 cap id, 0x41 next pointer, 0x43-0x42 command
`define LCCR_CAP_DW_IDX 6'h10
`define LCCR_OFF_CAP_ID 8'h40
`define LCCR_OFF_NEXT_PTR 8'h41
`define LCCR_OFF_CMD 8'h42

`define LCCR_CAP_ID_VAL 8'h08
`define LCCR_NEXT_PTR_NONE 8'h00
`define LCCR_NEXT_PTR_INTR 8'h78

// command register field positions
`define LCCR_CAP_TYPE_HI 15
`define LCCR_CAP_TYPE_LO 13
`define LCCR_DROP_BIT 12
`define LCCR_DIR_BIT 11
`define LCCR_MHOST_BIT 10
`define LCCR_UNIT_CNT_HI 9
`define LCCR_UNIT_CNT_LO 5
`define LCCR_UNIT_ID_HI 4
`define LCCR_UNIT_ID_LO 0

// fixed and reset values
`define LCCR_CAP_TYPE_VAL 3'h0
`define LCCR_UNIT_CNT_VAL 5'h01
`define LCCR_UNIT_ID_RST 5'h00
`define LCCR_DIR_RST 1'h0
`define LCCR_DROP_RST 1'h0
`define LCCR_MHOST_RST 1'h0

`endif

// *** verilog/lccr_pkg.sv ***
// types shared by the link capability register block
package lccr_pkg;

    typedef enum logic [1:0] {
        LCCR_MODE_SINGLE = 2'b00,
        LCCR_MODE_DUAL = 2'b01,
        LCCR_MODE_GEN_SINGLE = 2'b10,
        LCCR_MODE_GEN_DUAL = 2'b11
    } lccr_mode_t;

    typedef enum logic [1:0] {
        LCCR_GATE_IDLE = 2'b00,
        LCCR_GATE_STALL = 2'b01,
        LCCR_GATE_DONE = 2'b10
    } lccr_gate_t;

endpackage : lccr_pkg

// *** verilog/lccr_ctl_if.sv ***
// controls and link status passed from the register block to the forwarding gate
`timescale 1ns/1ps

interface lccr_ctl_if #(
    parameter int NUM_LINKS = 2
);
    logic generic_mode;
    logic drop_uninit;
    logic [NUM_LINKS-1:0] init_done;
    logic [NUM_LINKS-1:0] end_of_chain;
    logic [NUM_LINKS-1:0] pkt_valid;
    logic [NUM_LINKS-1:0] fwd_go;
    logic [NUM_LINKS-1:0] fwd_drop;
    logic [NUM_LINKS-1:0] fwd_stall;

    modport ctl (
        output generic_mode,
        output drop_uninit,
        output init_done,
        output end_of_chain,
        output pkt_valid,
        input fwd_go,
        input fwd_drop,
        input fwd_stall
    );

    modport gate (
        input generic_mode,
        input drop_uninit,
        input init_done,
        input end_of_chain,
        input pkt_valid,
        output fwd_go,
        output fwd_drop,
        output fwd_stall
    );
endinterface : lccr_ctl_if

// *** verilog/lccr_fwd_gate.sv ***
// per-link forwarding decision for packets arriving on a receiving link
`timescale 1ns/1ps

module lccr_fwd_gate #(
    parameter int NUM_LINKS = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic warm_rst_n,
    lccr_ctl_if.gate ctl
);
    lccr_pkg::lccr_gate_t state_reg [NUM_LINKS];

    // a waiting packet is held, not lost: the verdict is taken once a flag rises
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_LINKS; i++) begin
                state_reg[i] <= lccr_pkg::LCCR_GATE_IDLE;
            end
            ctl.fwd_go <= '0;
            ctl.fwd_drop <= '0;
            ctl.fwd_stall <= '0;
        end else if (!warm_rst_n) begin
            for (int i = 0; i < NUM_LINKS; i++) begin
                state_reg[i] <= lccr_pkg::LCCR_GATE_IDLE;
            end
            ctl.fwd_go <= '0;
            ctl.fwd_drop <= '0;
            ctl.fwd_stall <= '0;
        end else begin
            for (int i = 0; i < NUM_LINKS; i++) begin
                ctl.fwd_go[i] <= 1'b0;
                ctl.fwd_drop[i] <= 1'b0;
                ctl.fwd_stall[i] <= 1'b0;
                case (state_reg[i])
                    lccr_pkg::LCCR_GATE_IDLE,
                    lccr_pkg::LCCR_GATE_STALL: begin
                        if (!ctl.pkt_valid[i]) begin
                            state_reg[i] <= lccr_pkg::LCCR_GATE_IDLE;
                        end else if (ctl.end_of_chain[i]) begin
                            ctl.fwd_drop[i] <= 1'b1;
                            state_reg[i] <= lccr_pkg::LCCR_GATE_DONE;
                        end else if (ctl.init_done[i]) begin
                            ctl.fwd_go[i] <= 1'b1;
                            state_reg[i] <= lccr_pkg::LCCR_GATE_DONE;
                        end else if (ctl.generic_mode && ctl.drop_uninit) begin
                            ctl.fwd_drop[i] <= 1'b1;
                            state_reg[i] <= lccr_pkg::LCCR_GATE_DONE;
                        end else begin
                            ctl.fwd_stall[i] <= 1'b1;
                            state_reg[i] <= lccr_pkg::LCCR_GATE_STALL;
                        end
                    end
                    lccr_pkg::LCCR_GATE_DONE: begin
                        // the source drops pkt_valid for one cycle after a verdict
                        state_reg[i] <= lccr_pkg::LCCR_GATE_IDLE;
                    end
                    default: begin
                        state_reg[i] <= lccr_pkg::LCCR_GATE_IDLE;
                    end
                endcase
            end
        end
    end

endmodule : lccr_fwd_gate

// *** bench/lccr_link_cap_regs_properties.sv ***
// port checker for the link capability header block
`timescale 1ns/1ps
module lccr_props_chk #(
    parameter int NUM_LINKS = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic warm_rst_n,
    input wire logic [1:0] mode_strap,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_rvalid,
    input wire logic cfg_rhit,
    input wire logic [NUM_LINKS-1:0] link_init_done,
    input wire logic [NUM_LINKS-1:0] link_eoc,
    input wire logic [NUM_LINKS-1:0] pkt_valid,
    input wire logic [NUM_LINKS-1:0] fwd_go,
    input wire logic [NUM_LINKS-1:0] fwd_drop,
    input wire logic [NUM_LINKS-1:0] fwd_stall,
    input wire logic sec_addr_perr,
    input wire logic serr_en,
    input wire logic [4:0] base_unit_id,
    input wire logic sync_flood
);
    default clocking dcb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic hit_rd = cfg_rd && cfg_addr[7:2] == 6'h10;
    // gate only takes a packet when no verdict is showing
    wire logic idle0 = !fwd_go[0] && !fwd_drop[0] && warm_rst_n;
    property p_hdr_fixed;
        hit_rd |=> cfg_rhit && cfg_rdata[7:0] == 8'h08 && cfg_rdata[31:29] == 3'h0
            && cfg_rdata[25:21] == 5'h01;
    endproperty
    a_hdr_fixed: assert property (p_hdr_fixed) else $error("fixed field wrong");
    property p_next_ptr;
        hit_rd |=> cfg_rdata[15:8] == (mode_strap[1] ? 8'h78 : 8'h00);
    endproperty
    a_next_ptr: assert property (p_next_ptr) else $error("next pointer wrong");
    property p_base_id;
        cfg_wr && cfg_addr[7:2] == 6'h10 && cfg_be[2] && warm_rst_n
            |=> base_unit_id == $past(cfg_wdata[20:16]);
    endproperty
    a_base_id: assert property (p_base_id) else $error("base id not loaded");
    property p_warm;
        !warm_rst_n |=> base_unit_id == 5'h00 && !sync_flood;
    endproperty
    a_warm: assert property (p_warm) else $error("warm reset did not clear");
    property p_eoc_drop;
        pkt_valid[0] && link_eoc[0] && idle0 |=> fwd_drop[0] && !fwd_go[0];
    endproperty
    a_eoc_drop: assert property (p_eoc_drop) else $error("end of chain not dropped");
    property p_stall_go;
        fwd_stall[0] && pkt_valid[0] && link_init_done[0] && !link_eoc[0] && warm_rst_n
            |=> fwd_go[0] && !fwd_stall[0];
    endproperty
    a_stall_go: assert property (p_stall_go) else $error("stall did not release");
    property p_sync_set;
        sec_addr_perr && serr_en && mode_strap[1] && warm_rst_n |=> sync_flood;
    endproperty
    a_sync_set: assert property (p_sync_set) else $error("sync flood not raised");
    property p_sync_hold;
        sync_flood && warm_rst_n |=> sync_flood;
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("sync flood dropped");
    property p_rd_answer;
        cfg_rd |=> cfg_rvalid && cfg_rhit == $past(hit_rd);
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_rd_quiet;
        !cfg_rd |=> !cfg_rvalid && !cfg_rhit;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("answer without read");
endmodule : lccr_props_chk

bind lccr_link_cap_regs lccr_props_chk #(.NUM_LINKS(NUM_LINKS)) i_lccr_props_chk (
    .clk, .rst_n, .warm_rst_n, .mode_strap, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be,
    .cfg_wdata, .cfg_rdata, .cfg_rvalid, .cfg_rhit, .link_init_done, .link_eoc, .pkt_valid,
    .fwd_go, .fwd_drop, .fwd_stall, .sec_addr_perr, .serr_en, .base_unit_id, .sync_flood
);

// *** bench/lccr_host_model.sv ***
// upstream host model issuing config accesses
`timescale 1ns/1ps
module lccr_host_model (
    input wire logic clk,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_rhit,
    output logic cfg_wr,
    output logic cfg_rd,
    output logic [7:0] cfg_addr,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata,
    output logic cfg_link
);
    initial begin
        {cfg_wr, cfg_rd, cfg_link} = 3'h0;
        {cfg_addr, cfg_be, cfg_wdata} = 44'h0;
    end
    // released lines inverted so stale values never pass for a hold
    task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be,
        input logic [31:0] d, input logic l, output logic [31:0] q, output logic h);
        {cfg_wr, cfg_rd} = {w, !w};
        {cfg_addr, cfg_be, cfg_wdata, cfg_link} = {a, be, d, l};
        @(posedge clk) #1;
        // the hit flag stands for one cycle only, so take the answer now
        {q, h} = {cfg_rdata, cfg_rhit};
        {cfg_wr, cfg_rd} = 2'b00;
        {cfg_addr, cfg_wdata} = ~{cfg_addr, cfg_wdata};
        @(posedge clk) #1;
    endtask : acc
endmodule : lccr_host_model

// *** bench/tb_top.sv ***
// testbench for the link capability header block
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst_n, warm_rst_n, cfg_wr, cfg_rd, cfg_link, cfg_rvalid, cfg_rhit;
    logic sec_addr_perr, serr_en, req_link_sel, sync_flood;
    logic [1:0] mode_strap, link_init_done, link_eoc, pkt_valid, fwd_go, fwd_drop, fwd_stall;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic [4:0] base_unit_id;
    int fails = 0;
    int compares = 0;
    int cyc = 0;
    lccr_link_cap_regs i_lccr_link_cap_regs (.clk, .rst_n, .warm_rst_n, .mode_strap,
        .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_link, .cfg_rdata,
        .cfg_rvalid, .cfg_rhit, .link_init_done, .link_eoc, .pkt_valid, .fwd_go,
        .fwd_drop, .fwd_stall, .sec_addr_perr, .serr_en, .req_link_sel,
        .base_unit_id, .sync_flood);
    lccr_host_model i_lccr_host_model (.clk, .cfg_rdata, .cfg_rhit, .cfg_wr, .cfg_rd,
        .cfg_addr, .cfg_be, .cfg_wdata, .cfg_link);
    always #2.5 clk = ~clk;
    task automatic wrap_up;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    // whole run is some 150 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            wrap_up();
        end
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [3:0] be, input logic [31:0] d, input logic l);
        logic [31:0] q;
        logic h;
        i_lccr_host_model.acc(1'b1, 8'h40, be, d, l, q, h);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic l, input logic [31:0] e);
        logic [31:0] q;
        logic h;
        i_lccr_host_model.acc(1'b0, a, 4'h0, 32'h0, l, q, h);
        chk("cfg_rdata", q, e);
        chk("cfg_rhit", h, a[7:2] == 6'h10);
    endtask : rd_chk
    // exp holds go, drop, stall; rel ends the packet and lets the gate idle
    task automatic gate(input logic e, input logic i, input logic [2:0] exp, input logic rel);
        {link_eoc, link_init_done, pkt_valid} = {{2{e}}, {2{i}}, 2'b11};
        @(posedge clk) #1;
        chk("fwd_go", fwd_go, {2{exp[2]}});
        chk("fwd_drop", fwd_drop, {2{exp[1]}});
        chk("fwd_stall", fwd_stall, {2{exp[0]}});
        if (rel) begin
            {link_eoc, link_init_done, pkt_valid} = 6'h00;
            repeat (2) @(posedge clk) #1;
        end
    endtask : gate
    task automatic run(input logic [1:0] m);
        logic [15:0] lo;
        lo = {m[1] ? 8'h78 : 8'h00, 8'h08};
        rst_n = 1'b0;
        mode_strap = m;
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
        // the strap passes a synchroniser before the mode is caught
        repeat (4) @(posedge clk) #1;
        rd_chk(8'h40, 1'b0, {16'h0020, lo});
        wr(4'hf, 32'hffff_ffff, 1'b1);
        rd_chk(8'h40, 1'b1, {3'h0, m[1], 2'b11, 5'h01, 5'h1f, lo});
        chk("req_link_sel", req_link_sel, m[0]);
        gate(1'b0, 1'b0, {1'b0, m[1], !m[1]}, 1'b1);
        gate(1'b1, 1'b0, 3'b010, 1'b1);
        wr(4'hc, 32'h0005_0000, 1'b1);
        rd_chk(8'h40, 1'b0, {5'h00, !m[0], 5'h01, 5'h05, lo});
        chk("req_link_sel", req_link_sel, !m[0]);
        chk("base_unit_id", base_unit_id, 5'h05);
        rd_chk(8'h44, 1'b0, 32'h0);
        wr(4'hf, 32'hffff_ffff, 1'b1);
        warm_rst_n = 1'b0;
        @(posedge clk) #1;
        warm_rst_n = 1'b1;
        rd_chk(8'h40, 1'b0, {5'h00, !m[0], 5'h01, 5'h00, lo});
        gate(1'b0, 1'b0, 3'b001, 1'b0);
        gate(1'b0, 1'b1, 3'b100, 1'b1);
        {serr_en, sec_addr_perr} = 2'b11;
        @(posedge clk) #1;
        sec_addr_perr = 1'b0;
        @(posedge clk) #1;
        chk("sync_flood", sync_flood, m[1]);
        serr_en = 1'b0;
    endtask : run
    initial begin
        {rst_n, warm_rst_n, mode_strap, sec_addr_perr, serr_en} = 6'h10;
        {link_init_done, link_eoc, pkt_valid} = 6'h00;
        for (int m = 0; m < 4; m++) begin
            run(m[1:0]);
            $display("mode %0d test done", m);
        end
        wrap_up();
    end
endmodule : tb_top
